/* File: bench/test_ubw_port.sv */
// testbench: port and remote joined, port driven over registers
`timescale 1ns/1ps
module test_ubw_port;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] rdata;
  logic send_wake = 1'b0;
  logic send_byte = 1'b0;
  logic [7:0] byte_in = 8'h00;
  logic sync_pol = 1'b0;
  logic busy;
  logic [7:0] sync_rx;
  logic sync_rx_valid;
  logic amon = 1'b0;
  logic [12:0] fr;
  logic [7:0] b;
  logic [15:0] rmask[$];
  logic [15:0] rexp[$];
  logic [12:0] fexp[$];
  logic [7:0] sexp[$];
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 14926;
  ubw_if lnk();
  ubw_port ubw_port_i (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .lnk);
  // remote wake character is 13 bits, the first 10 of them zero, at the port's reset bit length
  ubw_remote #(.BIT_CYC(10), .WAKE_BITS(13)) ubw_remote_i (.clk, .reset_n,
    .send_wake, .send_byte, .byte_in, .sync_pol, .busy, .sync_rx, .sync_rx_valid, .lnk);
  ubw_assertions ubw_assertions_i (.clk, .reset_n, .dt_o_dev(lnk.dt_o_dev),
    .dt_oe_dev(lnk.dt_oe_dev), .ck_o_dev(lnk.ck_o_dev), .ck_oe_dev(lnk.ck_oe_dev),
    .dt_oe_far(lnk.dt_oe_far), .dt_line(lnk.dt_line));
  always #25 clk = ~clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test();
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read notes mask and expectation; the watcher checks the answer
  task rreg(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    rmask.push_back(m);
    rexp.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // remote requests are only offered while it is not busy
  task rem(input logic w, input logic [7:0] v);
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    send_wake <= w;
    send_byte <= !w;
    byte_in <= v;
    @(posedge clk);
    send_wake <= 1'b0;
    send_byte <= 1'b0;
  endtask
  // watcher: read data one cycle after the strobe, sync bytes, run ceiling
  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) chk(rdata & rmask.pop_front(), rexp.pop_front());
    if (sync_rx_valid === 1'b1) chk({8'h00, sync_rx}, {8'h00, sexp.pop_front()});
    if (cyc > 6000) begin
      bad_count++;
      stop_test();
    end
  end
  // async decoder on the clock pin: 13 mid-bit samples after a start bit
  always begin
    @(negedge lnk.ck_line iff amon);
    wt(15);
    for (int i = 0; i < 13; i++) begin
      fr[i] = lnk.ck_line;
      if (i < 12) wt(10);
    end
    chk({3'h0, fr}, {3'h0, fexp.pop_front()});
  end
  initial begin
    wt(3);
    reset_n <= 1'b1;
    rreg(ubw_pkg::ADR_STAT, 16'h001f, 16'h0013);
    // break then sync byte; the dummy value must not show on the line
    amon = 1'b1;
    wreg(ubw_pkg::ADR_CTRL, 16'h0019);
    fexp.push_back(13'h1000);
    b = $random(seed);
    wreg(ubw_pkg::ADR_TXD, {8'h00, b | 8'h01});
    fexp.push_back(13'h1f55);
    wreg(ubw_pkg::ADR_TXD, {8'h00, ubw_pkg::SYNC_BYTE});
    rreg(ubw_pkg::ADR_STAT, 16'h0003, 16'h0000);
    rreg(ubw_pkg::ADR_CTRL, 16'h0010, 16'h0010);
    wt(140);
    rreg(ubw_pkg::ADR_CTRL, 16'h0010, 16'h0000);
    wt(110);
    rreg(ubw_pkg::ADR_STAT, 16'h0003, 16'h0003);
    amon = 1'b0;
    // wake by zero character, then by a non-zero one that rises early
    for (int k = 0; k < 2; k++) begin
      rreg(ubw_pkg::ADR_STAT, 16'h0010, 16'h0010);
      wreg(ubw_pkg::ADR_CTRL, 16'h00c1);
      rem(k == 0, 8'hf1);
      wt(20);
      rreg(ubw_pkg::ADR_STAT, 16'h0004, 16'h0004);
      rreg(ubw_pkg::ADR_CTRL, 16'h0080, k ? 16'h0000 : 16'h0080);
      wt(130);
      rreg(ubw_pkg::ADR_CTRL, 16'h0080, 16'h0000);
      rreg(ubw_pkg::ADR_RXD, 16'h0000, 16'h0000);
      rreg(ubw_pkg::ADR_STAT, 16'h0004, 16'h0000);
    end
    b = $random(seed);
    rem(1'b0, b);
    wt(120);
    rreg(ubw_pkg::ADR_STAT, 16'h0004, 16'h0004);
    rreg(ubw_pkg::ADR_RXD, 16'h00ff, {8'h00, b});
    rem(1'b1, 8'h00);
    wt(140);
    rreg(ubw_pkg::ADR_STAT, 16'h000c, 16'h000c);
    rreg(ubw_pkg::ADR_RXD, 16'h00ff, 16'h0000);
    // second reset clears the remote's bit count left by async edges on the clock pin
    reset_n <= 1'b0;
    wt(3);
    reset_n <= 1'b1;
    // sync master, both polarities, two bytes back to back
    for (int p = 0; p < 2; p++) begin
      // settle the idle level in receive mode, remote sampling the other edge
      sync_pol <= !p[0];
      wreg(ubw_pkg::ADR_CTRL, p ? 16'h012f : 16'h002f);
      wt(6);
      sync_pol <= p[0];
      wreg(ubw_pkg::ADR_CTRL, p ? 16'h010f : 16'h000f);
      repeat (2) begin
        b = $random(seed);
        sexp.push_back(b);
        wreg(ubw_pkg::ADR_TXD, {8'h00, b});
      end
      rreg(ubw_pkg::ADR_STAT, 16'h0003, 16'h0000);
      wt(360);
      rreg(ubw_pkg::ADR_STAT, 16'h0003, 16'h0003);
    end
    // leave transmit so the clock count and idle level are checked
    wreg(ubw_pkg::ADR_CTRL, 16'h012f);
    wt(4);
    stop_test();
  end
endmodule

/* File: bench/ubw_assertions.sv */
// checker: line timing of the device end of the serial link
`timescale 1ns/1ps
module ubw_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // device drivers
  input wire logic dt_o_dev,
  input wire logic dt_oe_dev,
  input wire logic ck_o_dev,
  input wire logic ck_oe_dev,
  // remote driver and line
  input wire logic dt_oe_far,
  input wire logic dt_line
);
  logic idle_lvl;
  logic ck_q;
  logic [4:0] edge_cnt;
  logic [8:0] lowc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // idle level is learnt while the data pin is not driven; five bits so 16 edges do not wrap
  always_ff @(posedge clk) begin
    ck_q <= ck_o_dev;
    if (!dt_oe_dev) idle_lvl <= ck_o_dev;
    if (!dt_oe_dev) edge_cnt <= 5'h00;
    else if (ck_o_dev != ck_q && ck_o_dev != idle_lvl) edge_cnt <= edge_cnt + 5'h01;
    lowc <= (ck_oe_dev && !dt_oe_dev && !ck_o_dev) ? lowc + 9'h001 : 9'h000;
  end
  a_half_duplex: assert property (!(dt_oe_dev && dt_oe_far))
    else $error("both ends drive the data line");
  a_sync_ck_en: assert property (dt_oe_dev |-> ck_oe_dev)
    else $error("data pin driven without clock driver");
  a_data_lead: assert property (dt_oe_dev && $past(dt_oe_dev) && $changed(dt_o_dev)
    |-> $changed(ck_o_dev) && ck_o_dev != idle_lvl)
    else $error("sync data changed off the leading edge");
  a_ck_half: assert property ($changed(ck_o_dev) && dt_oe_dev && $past(dt_oe_dev)
    |=> $stable(ck_o_dev) [*8])
    else $error("sync clock half period too short");
  a_clk_count: assert property ($fell(dt_oe_dev)
    |-> edge_cnt[2:0] == 3'h0 && edge_cnt != 5'h00)
    else $error("clock edges not a whole number of bytes");
  a_idle_back: assert property ($fell(dt_oe_dev) |-> ck_o_dev == idle_lvl)
    else $error("sync clock not back at idle level");
  a_low_limit: assert property (lowc <= 9'h082)
    else $error("transmit line low longer than a break");
  a_break_len: assert property ($rose(ck_o_dev) && !dt_oe_dev && lowc > 9'h064
    |-> lowc == 9'h082)
    else $error("break low time wrong");
  c_break: cover property ($rose(ck_o_dev) && lowc == 9'h082);
  c_sync_end: cover property ($fell(dt_oe_dev));
  c_wake: cover property ($fell(dt_line) && !dt_oe_dev);
endmodule

/* File: common/ubw_if.sv */
// interface: the two serial lines between port and remote party
`timescale 1ns/1ps
interface ubw_if;
  logic dt_o_dev;
  logic dt_oe_dev;
  logic ck_o_dev;
  logic ck_oe_dev;
  logic dt_o_far;
  logic dt_oe_far;
  logic ck_o_far;
  logic ck_oe_far;
  // open wires resolved here: undriven line idles high like a pull-up
  wire dt_line = dt_oe_dev ? dt_o_dev : (dt_oe_far ? dt_o_far : 1'b1);
  wire ck_line = ck_oe_dev ? ck_o_dev : (ck_oe_far ? ck_o_far : 1'b1);
  modport device (output dt_o_dev, dt_oe_dev, ck_o_dev, ck_oe_dev, input dt_line, ck_line);
  modport remote (output dt_o_far, dt_oe_far, ck_o_far, ck_oe_far, input dt_line, ck_line);
endinterface

/* File: common/ubw_pkg.sv */
// package: constants, register map and types for the break/wake/sync serial port
// Summary of operation
// R01 - remote wake character: zero, at least 10 bits
// R02 - non-zero char: low start period is wake
// R03 - wake sets receive flag; rising edge clears enable
// R04 - receive data read clears wake flag
// R05 - software checks receive idle before enabling wake
// R06 - remote break long enough for oscillator start
// R07 - break: start, twelve zeros, stop bit
// R08 - send-break plus data write starts break, zeros
// R09 - send-break request clears after break stop bit
// R10 - shift empty flag covers break transmissions too
// R11 - LIN header: break, dummy write, then 55h
// R12 - transmit buffer flag shows data register empty
// R13 - received break: flag, framing error, data 00h
// R14 - wake: two transitions, interrupt, then next byte
// R15 - synchronous: half duplex, no start/stop bits
// R16 - master when sync, clock source, port enabled
// R17 - master drives clock pin, driver auto enabled
// R18 - exactly one clock cycle per data bit
// R19 - polarity select sets idle level and edge
// R20 - master transmit drives data and clock pins
// R21 - data waits while shift register busy
// R22 - data changes on leading edge, stable after
// R23 - wake is falling edge; reception suspended
// R24 - wake detection only in asynchronous mode
package ubw_pkg;
  // register addresses of the control port
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_STAT = 3'h1;
  localparam logic [2:0] ADR_TXD = 3'h2;
  localparam logic [2:0] ADR_RXD = 3'h3;
  localparam logic [2:0] ADR_BAUD = 3'h4;
  // control bit positions
  localparam int C_SERIAL_PORT_ENABLE = 0;
  localparam int C_SYNC = 1;
  localparam int C_MASTER_CLOCK_SOURCE = 2;
  localparam int C_TXON = 3;
  localparam int C_SEND_BREAK_REQUEST = 4;
  localparam int C_SINGLE_RECEIVE_ENABLE = 5;
  localparam int C_CONTINUOUS_RECEIVE_ENABLE = 6;
  localparam int C_WUE = 7;
  localparam int C_CLOCK_POLARITY_SELECT = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  // status bit positions
  localparam int S_TRANSMIT_BUFFER_FLAG = 0;
  localparam int S_SHIFT_EMPTY_FLAG = 1;
  localparam int S_RECEIVE_INTERRUPT_FLAG = 2;
  localparam int S_FRAMING_ERROR_FLAG = 3;
  localparam int S_RECEIVE_IDLE_FLAG = 4;
  // frame shapes
  localparam int BRK_ZEROS = 12;
  localparam int DATA_BITS = 8;
  localparam logic [15:0] BAUD_RST = 16'h0009;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_SYNC} ubw_tx_t;
endpackage

/* File: verilog/ubw_port.sv */
// device end: break, wake-on-break, async receive and sync master transmit
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module ubw_port (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // lines
  ubw_if.device lnk
);
  logic [ubw_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0] baud_r, baud_nxt;
  logic [15:0] rdata_nxt;
  logic [7:0] txbuf_r, txbuf_nxt;
  logic txfull_r, txfull_nxt;
  logic txbrk_r, txbrk_nxt;
  ubw_pkg::ubw_tx_t ts_r, ts_nxt;
  logic [7:0] tsr_r, tsr_nxt;
  logic sbrk_r, sbrk_nxt;
  logic [3:0] tbit_r, tbit_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic dto_r, dto_nxt;
  logic cko_r, cko_nxt;
  // receiver
  logic [3:0] rst_r, rst_nxt;
  logic [15:0] rcnt_r, rcnt_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic receive_interrupt_flag_r, receive_interrupt_flag_nxt;
  logic framing_error_flag_r, framing_error_flag_nxt;
  logic dt_s, dt_d_r;
  logic serial_port_enable, syncm, master, stx, wake_on_break_enable, tick;

  ubw_sync2 u_sync (.clk(clk), .reset_n(reset_n), .d(lnk.dt_line), .q(dt_s));

  assign serial_port_enable = ctrl_r[ubw_pkg::C_SERIAL_PORT_ENABLE];
  assign syncm = ctrl_r[ubw_pkg::C_SYNC];
  assign master = serial_port_enable & syncm & ctrl_r[ubw_pkg::C_MASTER_CLOCK_SOURCE]; // R16
  assign stx = master & ~ctrl_r[ubw_pkg::C_SINGLE_RECEIVE_ENABLE] & ~ctrl_r[ubw_pkg::C_CONTINUOUS_RECEIVE_ENABLE]; // R16
  assign wake_on_break_enable = ctrl_r[ubw_pkg::C_WUE] & ~syncm; // R24
  assign tick = (tcnt_r == 16'h0000);

  // register writes and reads; data outputs come from flops
  always_comb begin
    ctrl_nxt = ctrl_r;
    baud_nxt = baud_r;
    rdata_nxt = 16'h0000;
    if (wr && addr == ubw_pkg::ADR_CTRL) ctrl_nxt = wdata[ubw_pkg::CTRL_W-1:0];
    if (wr && addr == ubw_pkg::ADR_BAUD) baud_nxt = wdata;
    // hardware clears win over software writes of the same cycle
    if (sbrk_r && ts_r == ubw_pkg::TX_STOP && tick && tbit_r == 4'h0)
      ctrl_nxt[ubw_pkg::C_SEND_BREAK_REQUEST] = 1'b0; // R09
    if (wake_on_break_enable && dt_s && !dt_d_r) ctrl_nxt[ubw_pkg::C_WUE] = 1'b0; // R03
    if (rd) begin
      unique case (addr)
        ubw_pkg::ADR_CTRL: rdata_nxt = {7'h00, ctrl_r};
        ubw_pkg::ADR_STAT: rdata_nxt = {11'h000, (rst_r == 4'h0), framing_error_flag_r, receive_interrupt_flag_r,
                                        (ts_r == ubw_pkg::TX_IDLE), ~txfull_r}; // R10 R12
        ubw_pkg::ADR_RXD: rdata_nxt = {8'h00, rxd_r};
        ubw_pkg::ADR_BAUD: rdata_nxt = baud_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // transmitter: async frames, breaks, sync master bytes
  always_comb begin
    txbuf_nxt = txbuf_r;
    txfull_nxt = txfull_r;
    txbrk_nxt = txbrk_r;
    ts_nxt = ts_r;
    tsr_nxt = tsr_r;
    sbrk_nxt = sbrk_r;
    tbit_nxt = tbit_r;
    tcnt_nxt = tick ? baud_r : tcnt_r - 16'h0001;
    dto_nxt = dto_r;
    cko_nxt = cko_r;
    if (wr && addr == ubw_pkg::ADR_TXD && ctrl_r[ubw_pkg::C_TXON]) begin
      txbuf_nxt = wdata[7:0];
      txfull_nxt = 1'b1;
      // a write while a break is still going out is the preloaded next byte
      txbrk_nxt = ctrl_r[ubw_pkg::C_SEND_BREAK_REQUEST] & ~syncm & ~sbrk_r; // R08 R09
    end
    unique case (ts_r)
      ubw_pkg::TX_IDLE: begin
        // sync data holds its last bit until the next leading edge
        if (!stx) dto_nxt = 1'b1; // R22
        cko_nxt = ctrl_r[ubw_pkg::C_CLOCK_POLARITY_SELECT]; // R19
        if (txfull_nxt && serial_port_enable) begin // R21
          tsr_nxt = txbrk_nxt ? 8'h00 : txbuf_nxt; // R08
          sbrk_nxt = txbrk_nxt;
          txfull_nxt = 1'b0;
          tcnt_nxt = baud_r;
          tbit_nxt = 4'h0;
          if (stx) begin
            ts_nxt = ubw_pkg::TX_SYNC; // R15
            dto_nxt = txbuf_nxt[0];
            cko_nxt = ~ctrl_r[ubw_pkg::C_CLOCK_POLARITY_SELECT]; // R22
          end else begin
            ts_nxt = ubw_pkg::TX_START;
            dto_nxt = 1'b0;
          end
        end
      end
      ubw_pkg::TX_START: if (tick) begin
        ts_nxt = ubw_pkg::TX_DATA;
        dto_nxt = tsr_r[0];
        tbit_nxt = sbrk_r ? 4'(ubw_pkg::BRK_ZEROS - 1) : 4'(ubw_pkg::DATA_BITS - 1); // R07
      end
      ubw_pkg::TX_DATA: if (tick) begin
        tsr_nxt = {1'b0, tsr_r[7:1]};
        if (tbit_r == 4'h0) begin
          ts_nxt = ubw_pkg::TX_STOP;
          dto_nxt = 1'b1;
        end else begin
          tbit_nxt = tbit_r - 4'h1;
          dto_nxt = sbrk_r ? 1'b0 : tsr_r[1]; // R07
        end
      end
      ubw_pkg::TX_STOP: if (tick) begin
        ts_nxt = ubw_pkg::TX_IDLE;
        sbrk_nxt = 1'b0;
      end
      ubw_pkg::TX_SYNC: if (tick) begin
        // half period: trailing edge, then leading edge with new bit
        if (cko_r != ctrl_r[ubw_pkg::C_CLOCK_POLARITY_SELECT]) begin
          cko_nxt = ctrl_r[ubw_pkg::C_CLOCK_POLARITY_SELECT];
          // a full idle half period follows the last trailing edge
          if (tbit_r == 4'(ubw_pkg::DATA_BITS - 1)) ts_nxt = ubw_pkg::TX_STOP; // R18
          else tbit_nxt = tbit_r + 4'h1;
        end else begin
          cko_nxt = ~ctrl_r[ubw_pkg::C_CLOCK_POLARITY_SELECT]; // R22
          tsr_nxt = {1'b0, tsr_r[7:1]};
          dto_nxt = tsr_r[1];
        end
      end
      default: ts_nxt = ubw_pkg::TX_IDLE;
    endcase
  end

  // async receiver; suspended while waiting for wake
  always_comb begin
    rst_nxt = rst_r;
    rcnt_nxt = (rcnt_r == 16'h0000) ? baud_r : rcnt_r - 16'h0001;
    rsh_nxt = rsh_r;
    rxd_nxt = rxd_r;
    receive_interrupt_flag_nxt = receive_interrupt_flag_r;
    framing_error_flag_nxt = framing_error_flag_r;
    if (rd && addr == ubw_pkg::ADR_RXD) receive_interrupt_flag_nxt = 1'b0; // R04
    if (wake_on_break_enable) begin
      rst_nxt = 4'h0; // R23
      if (!dt_s && dt_d_r) begin
        receive_interrupt_flag_nxt = 1'b1; // R02 R03 R14 R23
        rxd_nxt = 8'h00;
      end
    end else if (serial_port_enable && !syncm && ctrl_r[ubw_pkg::C_CONTINUOUS_RECEIVE_ENABLE]) begin
      if (rst_r == 4'h0) begin
        if (!dt_s && dt_d_r) begin
          rst_nxt = 4'h1;
          rcnt_nxt = {1'b0, baud_r[15:1]}; // sample mid-bit
        end
      end else if (rcnt_r == 16'h0000) begin
        if (rst_r == 4'h1) begin
          rst_nxt = dt_s ? 4'h0 : 4'h2; // glitch rejects start
        end else if (rst_r < 4'(ubw_pkg::DATA_BITS + 2)) begin
          rsh_nxt = {dt_s, rsh_r[7:1]};
          rst_nxt = rst_r + 4'h1;
        end else begin
          rxd_nxt = rsh_r; // R13
          framing_error_flag_nxt = ~dt_s; // R13
          receive_interrupt_flag_nxt = 1'b1; // R13
          rst_nxt = 4'h0;
        end
      end
    end else begin
      rst_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_r <= ubw_pkg::CTRL_RST;
      baud_r <= ubw_pkg::BAUD_RST;
      rdata <= 16'h0000;
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
      txbrk_r <= 1'b0;
      ts_r <= ubw_pkg::TX_IDLE;
      tsr_r <= 8'h00;
      sbrk_r <= 1'b0;
      tbit_r <= 4'h0;
      tcnt_r <= 16'h0000;
      dto_r <= 1'b1;
      cko_r <= 1'b0;
      rst_r <= 4'h0;
      rcnt_r <= 16'h0000;
      rsh_r <= 8'h00;
      rxd_r <= 8'h00;
      receive_interrupt_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      dt_d_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      baud_r <= baud_nxt;
      rdata <= rdata_nxt;
      txbuf_r <= txbuf_nxt;
      txfull_r <= txfull_nxt;
      txbrk_r <= txbrk_nxt;
      ts_r <= ts_nxt;
      tsr_r <= tsr_nxt;
      sbrk_r <= sbrk_nxt;
      tbit_r <= tbit_nxt;
      tcnt_r <= tcnt_nxt;
      dto_r <= dto_nxt;
      cko_r <= cko_nxt;
      rst_r <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      rsh_r <= rsh_nxt;
      rxd_r <= rxd_nxt;
      receive_interrupt_flag_r <= receive_interrupt_flag_nxt;
      framing_error_flag_r <= framing_error_flag_nxt;
      dt_d_r <= dt_s;
    end
  end

  // pin drivers: async TX on clock pin; sync master transmit drives both
  always_comb begin
    lnk.ck_oe_dev = serial_port_enable & (master | ~syncm); // R17 R20
    lnk.ck_o_dev = syncm ? cko_r : dto_r; // R17 R19
    lnk.dt_oe_dev = stx; // R15 R20
    lnk.dt_o_dev = dto_r; // R20
  end
endmodule

/* File: verilog/ubw_remote.sv */
// remote end: sends wake breaks and async bytes, samples sync master data
`timescale 1ns/1ps
module ubw_remote #(
  parameter int BIT_CYC = 10,
  parameter int WAKE_BITS = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // user side
  input wire logic send_wake,
  input wire logic send_byte,
  input wire logic [7:0] byte_in,
  input wire logic sync_pol,
  output logic busy,
  output logic [7:0] sync_rx,
  output logic sync_rx_valid,
  // lines
  ubw_if.remote lnk
);
  if (WAKE_BITS < 10 || WAKE_BITS > 31 || BIT_CYC < 1) begin : g_bad_param
    $error("ubw_remote: bad parameters");
  end
  logic [15:0] cnt_r, cnt_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic busy_nxt;
  logic ck_s, ck_d_r;
  logic dt_s;
  logic [7:0] srx_r, srx_nxt;
  logic [3:0] sn_r, sn_nxt;
  logic [7:0] rxo_nxt;
  logic vld_nxt;

  ubw_sync2 u_ck (.clk(clk), .reset_n(reset_n), .d(lnk.ck_line), .q(ck_s));
  // data passes the same two flops as the clock, so both stay aligned
  ubw_sync2 u_dt (.clk(clk), .reset_n(reset_n), .d(lnk.dt_line), .q(dt_s));

  // wake char is ten zeros then ones, WAKE_BITS long, then idle
  always_comb begin
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    busy_nxt = busy;
    if (!busy) begin
      if (send_wake) begin
        busy_nxt = 1'b1;
        bits_nxt = 5'(WAKE_BITS); // R01 R06
        sh_nxt = 10'h000;
        cnt_nxt = 16'(BIT_CYC - 1);
      end else if (send_byte) begin
        busy_nxt = 1'b1;
        bits_nxt = 5'h0a;
        sh_nxt = {1'b1, byte_in, 1'b0};
        cnt_nxt = 16'(BIT_CYC - 1);
      end
    end else if (cnt_r == 16'h0000) begin
      cnt_nxt = 16'(BIT_CYC - 1);
      sh_nxt = {1'b1, sh_r[9:1]};
      bits_nxt = bits_r - 5'h01;
      if (bits_r == 5'h01) busy_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  // sample data on trailing clock edge
  always_comb begin
    srx_nxt = srx_r;
    sn_nxt = sn_r;
    rxo_nxt = sync_rx;
    vld_nxt = 1'b0;
    if (ck_s != ck_d_r && ck_s == sync_pol) begin
      srx_nxt = {dt_s, srx_r[7:1]};
      if (sn_r == 4'h7) begin
        sn_nxt = 4'h0;
        rxo_nxt = {dt_s, srx_r[7:1]};
        vld_nxt = 1'b1;
      end else sn_nxt = sn_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_r <= 16'h0000;
      bits_r <= 5'h00;
      sh_r <= 10'h3ff;
      busy <= 1'b0;
      ck_d_r <= 1'b1;
      srx_r <= 8'h00;
      sn_r <= 4'h0;
      sync_rx <= 8'h00;
      sync_rx_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      busy <= busy_nxt;
      ck_d_r <= ck_s;
      srx_r <= srx_nxt;
      sn_r <= sn_nxt;
      sync_rx <= rxo_nxt;
      sync_rx_valid <= vld_nxt;
    end
  end

  // drives data line only while sending
  always_comb begin
    lnk.dt_oe_far = busy;
    lnk.dt_o_far = busy ? sh_r[0] : 1'b1;
    lnk.ck_oe_far = 1'b0;
    lnk.ck_o_far = 1'b1;
  end
endmodule

/* File: verilog/ubw_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ubw_sync2 (
  // clocking
  input wire logic clk,
  input wire logic reset_n,
  // signal
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s1_nxt;
  logic q_nxt;

  // first stage feeds only the second
  always_comb begin
    s1_nxt = d;
    q_nxt = s1_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= 1'b1;
      q <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      q <= q_nxt;
    end
  end
endmodule
